/* anp_consts.svh */
// Purpose: Offsets, field positions, reset values for the next-page register bank
// Assumes: 16-bit management registers, 5-bit register address
// Notes:   Definitions only
`ifndef ANP_CONSTS_SVH
`define ANP_CONSTS_SVH

// Register addresses
`define ANP_ADDR_W          5
`define ANP_EXP_ADDR        5'h06
`define ANP_NPTX_ADDR       5'h07
`define ANP_NPRX_ADDR       5'h08

// Expansion status field positions
`define ANP_EXP_PDF_BIT     4
`define ANP_EXP_LPNP_BIT    3
`define ANP_EXP_NPABLE_BIT  2
`define ANP_EXP_PAGE_BIT    1
`define ANP_EXP_LPAN_BIT    0

// Next-page word field positions
`define ANP_NP_BIT          15
`define ANP_RSV_BIT         14
`define ANP_MSG_BIT         13
`define ANP_ACK2_BIT        12
`define ANP_TOG_BIT         11
`define ANP_CODE_HI         10
`define ANP_CODE_LO         0

// Reset values
`define ANP_NP_RST          1'h0
`define ANP_RSV_RST         1'h0
`define ANP_MSG_RST         1'h1
`define ANP_ACK2_RST        1'h0
`define ANP_TOG_RST         1'h0
`define ANP_CODE_RST        11'h001
`define ANP_NPRX_RST        16'h0000
`define ANP_RD_RST          16'h0000

// Flag indices in the latched flag array
`define ANP_FLAG_N          3
`define ANP_FLAG_PDF        0
`define ANP_FLAG_PAGE       1
`define ANP_FLAG_LPAN       2

`endif

/* anp_pkg.sv */
// Purpose: Types shared by the next-page register bank
// Assumes: Constants live in anp_consts.svh
// Notes:   Types only
package anp_pkg;
   typedef logic [4:0]  anp_addr_t;
   typedef logic [15:0] anp_word_t;
   typedef logic [10:0] anp_code_t;
endpackage : anp_pkg

/* anp_lh_flag.sv */
// Purpose: One latched-high flag cleared by a register read
// Assumes: Synchronous active-low reset
// Notes:   A set in the clearing cycle wins
`timescale 1ns/100ps
`default_nettype none
module anp_lh_flag
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic set_in,
   input  wire logic clear_in,
   output var  logic flag_out
);
   logic flag_reg;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         flag_reg <= 1'h0;
      end
      else if (set_in)
      begin
         flag_reg <= 1'h1;
      end
      else if (clear_in)
      begin
         flag_reg <= 1'h0;
      end
   end

   assign flag_out = flag_reg;
endmodule : anp_lh_flag
`default_nettype wire

/* anp_regs.sv */
// Purpose: Expansion status and next-page exchange registers of one port
// Assumes: Management port and arbitration inputs synchronous to clk (40 MHz)
// Notes:   Read data is registered one cycle after rd_en
`timescale 1ns/100ps
`include "anp_consts.svh"
`default_nettype none
module anp_regs
(
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Management register port
   input  wire anp_pkg::anp_addr_t reg_addr,
   input  wire logic              rd_en,
   input  wire logic              wr_en,
   input  wire anp_pkg::anp_word_t wr_data,
   output var  anp_pkg::anp_word_t rd_data,
   // Arbitration side
   input  wire logic              pd_fault,
   input  wire logic              page_rx_ack,
   input  wire anp_pkg::anp_word_t rx_page,
   input  wire logic              lp_np_able,
   input  wire logic              lp_an_able,
   input  wire logic              local_np_able,
   input  wire logic              tx_page_sent,
   input  wire logic              an_restart,
   output var  anp_pkg::anp_word_t np_tx_word,
   output var  logic              np_tx_loaded,
   output var  logic              rx_toggle_err
);
   import anp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   logic rd_exp;
   logic wr_nptx;
   logic [`ANP_FLAG_N-1:0] flag_set;
   logic [`ANP_FLAG_N-1:0] flag_q;

   assign rd_exp  = rd_en && (reg_addr == `ANP_EXP_ADDR);
   assign wr_nptx = wr_en && (reg_addr == `ANP_NPTX_ADDR);

   ////////////////////////////////////////////////////////////////////////////
   // Latched-high status flags, cleared by reading the expansion register
   assign flag_set[`ANP_FLAG_PDF]  = pd_fault;
   assign flag_set[`ANP_FLAG_PAGE] = page_rx_ack;
   assign flag_set[`ANP_FLAG_LPAN] = lp_an_able;

   genvar gi;
   generate
      for (gi = 0; gi < `ANP_FLAG_N; gi = gi + 1)
      begin : g_flag
         anp_lh_flag u_flag
         (
            .clk      (clk),
            .reset_n  (reset_n),
            .set_in   (flag_set[gi]),
            .clear_in (rd_exp),
            .flag_out (flag_q[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Local next page to transmit
   logic      np_reg;
   logic      rsv_reg;
   logic      msg_reg;
   logic      ack2_reg;
   logic      tog_reg;
   anp_code_t code_reg;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         np_reg   <= `ANP_NP_RST;
         rsv_reg  <= `ANP_RSV_RST;
         msg_reg  <= `ANP_MSG_RST;
         ack2_reg <= `ANP_ACK2_RST;
         code_reg <= `ANP_CODE_RST;
      end
      else if (wr_nptx)
      begin
         np_reg   <= wr_data[`ANP_NP_BIT];
         rsv_reg  <= wr_data[`ANP_RSV_BIT];
         msg_reg  <= wr_data[`ANP_MSG_BIT];
         ack2_reg <= wr_data[`ANP_ACK2_BIT];
         code_reg <= wr_data[`ANP_CODE_HI:`ANP_CODE_LO];
      end
   end

   // Toggle flips every transmitted word so the partner sees alternation
   always_ff @(posedge clk)
   begin
      if (!reset_n || an_restart)
      begin
         tog_reg <= `ANP_TOG_RST;
      end
      else if (tx_page_sent)
      begin
         tog_reg <= ~tog_reg;
      end
   end

   // Loaded marker: set by a write, dropped when the page goes out
   always_ff @(posedge clk)
   begin
      if (!reset_n || an_restart)
      begin
         np_tx_loaded <= 1'h0;
      end
      else if (wr_nptx)
      begin
         np_tx_loaded <= 1'h1;
      end
      else if (tx_page_sent)
      begin
         np_tx_loaded <= 1'h0;
      end
   end

   always_comb
   begin
      np_tx_word = {np_reg, rsv_reg, msg_reg, ack2_reg, tog_reg, code_reg};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Partner next page, loaded with the page-received flag
   anp_word_t nprx_reg;
   logic      rx_tog_reg;
   logic      rx_seen_reg;

   always_ff @(posedge clk)
   begin
      if (!reset_n || an_restart)
      begin
         nprx_reg <= `ANP_NPRX_RST;
      end
      else if (page_rx_ack)
      begin
         nprx_reg <= rx_page;
      end
   end

   // Partner toggle must alternate between successive pages
   always_ff @(posedge clk)
   begin
      if (!reset_n || an_restart)
      begin
         rx_tog_reg    <= 1'h0;
         rx_seen_reg   <= 1'h0;
         rx_toggle_err <= 1'h0;
      end
      else
      begin
         rx_toggle_err <= 1'h0;
         if (page_rx_ack)
         begin
            rx_tog_reg    <= rx_page[`ANP_TOG_BIT];
            rx_seen_reg   <= 1'h1;
            rx_toggle_err <= rx_seen_reg && (rx_page[`ANP_TOG_BIT] == rx_tog_reg);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux
   anp_word_t rd_next;

   always_comb
   begin
      rd_next = `ANP_RD_RST;
      if (rd_en)
      begin
         case (reg_addr)
            `ANP_EXP_ADDR:
            begin
               rd_next[`ANP_EXP_PDF_BIT]    = flag_q[`ANP_FLAG_PDF];
               rd_next[`ANP_EXP_LPNP_BIT]   = lp_np_able;
               rd_next[`ANP_EXP_NPABLE_BIT] = local_np_able;
               rd_next[`ANP_EXP_PAGE_BIT]   = flag_q[`ANP_FLAG_PAGE];
               rd_next[`ANP_EXP_LPAN_BIT]   = flag_q[`ANP_FLAG_LPAN];
            end
            `ANP_NPTX_ADDR:
            begin
               rd_next = np_tx_word;
            end
            `ANP_NPRX_ADDR:
            begin
               rd_next = nprx_reg;
            end
            default:
            begin
               rd_next = `ANP_RD_RST;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         rd_data <= `ANP_RD_RST;
      end
      else
      begin
         rd_data <= rd_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   pdf_set_a: assert property (@(posedge clk) disable iff (!reset_n)
      pd_fault |=> flag_q[`ANP_FLAG_PDF])
      else $error("fault flag not latched");

   pdf_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      (rd_exp && !pd_fault) |=> !flag_q[`ANP_FLAG_PDF])
      else $error("fault flag not cleared by read");

   lpnp_mirror_a: assert property (@(posedge clk) disable iff (!reset_n)
      rd_exp |=> (rd_data[`ANP_EXP_LPNP_BIT] == $past(lp_np_able)))
      else $error("partner next-page bit mismatch");

   page_set_a: assert property (@(posedge clk) disable iff (!reset_n)
      page_rx_ack |=> flag_q[`ANP_FLAG_PAGE] ##1 (flag_q[`ANP_FLAG_PAGE] || $past(rd_exp)))
      else $error("page flag not latched");

   page_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (flag_q[`ANP_FLAG_PAGE] && !rd_exp) |=> flag_q[`ANP_FLAG_PAGE])
      else $error("page flag dropped without read");

   lpan_set_a: assert property (@(posedge clk) disable iff (!reset_n)
      lp_an_able |=> flag_q[`ANP_FLAG_LPAN])
      else $error("autoneg able not reported");

   lpan_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      (rd_exp && !lp_an_able) |=> !flag_q[`ANP_FLAG_LPAN])
      else $error("autoneg able set without partner");

   np_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_nptx && !an_restart) |=> (np_tx_word[`ANP_NP_BIT] == $past(wr_data[`ANP_NP_BIT])) && np_tx_loaded)
      else $error("next page bit not written");

   msg_ack2_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_nptx |=> np_tx_word[`ANP_MSG_BIT:`ANP_ACK2_BIT] == $past(wr_data[`ANP_MSG_BIT:`ANP_ACK2_BIT]))
      else $error("message or ack2 bit not written");

   toggle_flip_a: assert property (@(posedge clk) disable iff (!reset_n)
      (tx_page_sent && !an_restart) |=> (np_tx_word[`ANP_TOG_BIT] != $past(np_tx_word[`ANP_TOG_BIT])))
      else $error("toggle did not invert");

   toggle_ro_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_nptx && !tx_page_sent && !an_restart) |=> $stable(np_tx_word[`ANP_TOG_BIT]))
      else $error("toggle changed by write");

   code_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_nptx |=> np_tx_word[`ANP_CODE_HI:`ANP_CODE_LO] == $past(wr_data[`ANP_CODE_HI:`ANP_CODE_LO]))
      else $error("code field not carried");

   rx_load_a: assert property (@(posedge clk) disable iff (!reset_n)
      (page_rx_ack && !an_restart) |=> (nprx_reg == $past(rx_page)) && flag_q[`ANP_FLAG_PAGE])
      else $error("partner page not loaded with flag");

   rx_read_a: assert property (@(posedge clk) disable iff (!reset_n)
      (rd_en && reg_addr == `ANP_NPRX_ADDR) |=> rd_data == $past(nprx_reg))
      else $error("partner page read mismatch");

   read_prio_c:  cover property (@(posedge clk) disable iff (!reset_n) rd_exp && page_rx_ack);
   page_read_c:  cover property (@(posedge clk) disable iff (!reset_n) page_rx_ack ##[1:20] rd_exp);
   tx_cycle_c:   cover property (@(posedge clk) disable iff (!reset_n) wr_nptx ##[1:20] tx_page_sent);
   tog_err_c:    cover property (@(posedge clk) disable iff (!reset_n) rx_toggle_err);
endmodule : anp_regs
`default_nettype wire

/* anp_arb_model.sv */
// Purpose: Arbitration-side model driving page events and partner abilities
// Assumes: Driven on the falling edge, active only while act is high
// Notes:   Page bus shows the inverse of its last value between pages
`timescale 1ns/100ps
`default_nettype none
module anp_arb_model
(
   input  wire logic              clk,
   input  wire logic              act,
   input  wire logic              np_tx_loaded,
   output var  logic              pd_fault,
   output var  logic              page_rx_ack,
   output var  anp_pkg::anp_word_t rx_page,
   output var  logic              lp_np_able,
   output var  logic              lp_an_able,
   output var  logic              local_np_able,
   output var  logic              tx_page_sent
);
   import anp_pkg::*;
   logic tog;
   initial
   begin
      {pd_fault, page_rx_ack, lp_np_able, lp_an_able, local_np_able, tx_page_sent, tog} = 7'h00;
      rx_page = 16'h0000;
   end
   always @(negedge clk)
   begin
      pd_fault     = act && ($urandom % 40 == 0);
      tx_page_sent = act && np_tx_loaded && ($urandom % 4 == 0);
      if (act && ($urandom % 5 == 0))
      begin
         rx_page     = anp_word_t'($urandom);
         rx_page[11] = tog;
         // Occasional repeated toggle exercises the partner toggle check
         if ($urandom % 8 != 0) tog = ~tog;
         page_rx_ack = 1'h1;
      end
      else
      begin
         page_rx_ack = 1'h0;
         rx_page     = ~rx_page;
      end
      if (act && ($urandom % 30 == 0)) lp_an_able = ~lp_an_able;
      if (act && ($urandom % 30 == 0)) lp_np_able = ~lp_np_able;
      if (act && ($urandom % 30 == 0)) local_np_able = ~local_np_able;
   end
endmodule : anp_arb_model
`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for the next-page register bank
// Assumes: Inputs driven on the falling edge of a 40 MHz clock
// Notes:   Reference model updates on the rising edge from the driven inputs
`timescale 1ns/100ps
`include "anp_consts.svh"
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t got %h expected %h", $time, (a), (e)); end end
module tb;
   import anp_pkg::*;
   logic      clk = 1'h0;
   logic      reset_n = 1'h0;
   logic      rd_en = 1'h0, wr_en = 1'h0, an_restart = 1'h0, act = 1'h0, chk_on = 1'h0;
   anp_addr_t reg_addr = 5'h00;
   anp_word_t wr_data = 16'h0000, rd_data, np_tx_word, rx_page, d;
   logic      np_tx_loaded, pd_fault, page_rx_ack, lp_np_able, lp_an_able, local_np_able, tx_page_sent;
   logic      m_pdf, m_pg, m_an, m_tog, m_ld, m_rtog, m_seen, m_err, rx_toggle_err;
   anp_word_t m_tx, m_rx, m_rd;
   int        bad_count = 0, check_count = 0, cycles = 0;
   always #12.5 clk = ~clk;
   anp_regs u_dut (.clk, .reset_n, .reg_addr, .rd_en, .wr_en, .wr_data, .rd_data, .pd_fault, .page_rx_ack,
      .rx_page, .lp_np_able, .lp_an_able, .local_np_able, .tx_page_sent, .an_restart, .np_tx_word,
      .np_tx_loaded, .rx_toggle_err);
   anp_arb_model u_arb (.clk, .act, .np_tx_loaded, .pd_fault, .page_rx_ack, .rx_page, .lp_np_able,
      .lp_an_able, .local_np_able, .tx_page_sent);
   ////////////////////////////////////////////////////////////////////////////
   // Reference model
   always @(posedge clk)
   begin
      m_rd  = 16'h0000;
      m_err = 1'h0;
      if (!reset_n)
      begin
         {m_pdf, m_pg, m_an, m_tog, m_ld, m_rtog, m_seen} = 7'h00;
         m_tx = 16'h2001;
         m_rx = 16'h0000;
      end
      else
      begin
         if (rd_en && reg_addr == `ANP_EXP_ADDR)
            m_rd = {11'h000, m_pdf, lp_np_able, local_np_able, m_pg, m_an};
         if (rd_en && reg_addr == `ANP_NPTX_ADDR) m_rd = {m_tx[15:12], m_tog, m_tx[10:0]};
         if (rd_en && reg_addr == `ANP_NPRX_ADDR) m_rd = m_rx;
         if (rd_en && reg_addr == `ANP_EXP_ADDR) {m_pdf, m_pg, m_an} = 3'h0;
         m_pdf = m_pdf | pd_fault;
         m_pg  = m_pg | page_rx_ack;
         m_an  = m_an | lp_an_able;
         if (page_rx_ack) m_rx = rx_page;
         if (page_rx_ack)
         begin
            m_err  = m_seen && (rx_page[11] == m_rtog);
            m_rtog = rx_page[11];
            m_seen = 1'h1;
         end
         if (tx_page_sent) {m_tog, m_ld} = {~m_tog, 1'h0};
         if (wr_en && reg_addr == `ANP_NPTX_ADDR) {m_tx, m_ld} = {wr_data, 1'h1};
         if (an_restart) {m_tog, m_ld, m_rx, m_rtog, m_seen, m_err} = 21'h000000;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Comparison every cycle and hang guard
   always @(negedge clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         bad_count++;
         end_sim();
      end
      if (chk_on)
      begin
         `CHK(rd_data, m_rd)
         `CHK(np_tx_word, {m_tx[15:12], m_tog, m_tx[10:0]})
         `CHK(np_tx_loaded, m_ld)
         `CHK(rx_toggle_err, m_err)
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic op(input anp_addr_t a, input logic r, input logic w, input anp_word_t dat);
      @(negedge clk);
      {reg_addr, rd_en, wr_en, wr_data} = {a, r, w, dat};
      @(negedge clk);
      {rd_en, wr_en} = 2'h0;
   endtask : op
   task automatic do_reset();
      @(negedge clk);
      reset_n = 1'h0;
      chk_on  = 1'h1;
      repeat (4) @(negedge clk);
      reset_n = 1'h1;
   endtask : do_reset
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h2d11));
      do_reset();
      for (int i = 5; i < 10; i++) op(anp_addr_t'(i), 1'h1, 1'h0, 16'h0000);
      $display("test reset_values done");
      for (int r = 0; r < 24; r++)
      begin
         if (r == 12)
         begin
            do_reset();
            $display("test mid_run_reset done");
         end
         d = anp_word_t'($urandom);
         if (r % 2 == 1) d[13] = 1'h0;
         op(`ANP_NPTX_ADDR, 1'h1, 1'h1, d);
         op(anp_addr_t'(6 + $urandom % 3), 1'h0, 1'h1, anp_word_t'($urandom));
         op(`ANP_NPTX_ADDR, 1'h1, 1'h0, 16'h0000);
         if (r % 5 == 4)
         begin
            @(negedge clk);
            an_restart = 1'h1;
            @(negedge clk);
            an_restart = 1'h0;
         end
         act = 1'h1;
         repeat (40) op(($urandom % 4 == 0) ? anp_addr_t'($urandom) : anp_addr_t'(6 + $urandom % 3),
            1'h1, 1'h0, 16'h0000);
         act = 1'h0;
      end
      $display("test exchange_rounds done");
      end_sim();
   end
endmodule : tb
`default_nettype wire
